/* agm_pkg.sv */
// Package for the modulo and bit-reversed address generator.
// Assumes a 16-bit byte-addressed data space and sixteen working registers.
package agm_pkg;
	// Register offsets on the plain register port
	localparam logic [2:0] OFS_CONTROL = 3'h0;
	localparam logic [2:0] OFS_X_START = 3'h1;
	localparam logic [2:0] OFS_X_END = 3'h2;
	localparam logic [2:0] OFS_Y_START = 3'h3;
	localparam logic [2:0] OFS_Y_END = 3'h4;
	localparam logic [2:0] OFS_BITREV = 3'h5;
	// Control and bit-reverse register field positions
	localparam int XSEL_LSB = 0;
	localparam int YSEL_LSB = 4;
	localparam int BRSEL_LSB = 8;
	localparam int YEN_BIT = 14;
	localparam int XEN_BIT = 15;
	localparam int BITREV_ENABLE_BIT = 15;
	// Reset values
	localparam logic [15:0] CONTROL_RST = 16'h0FFF;
	localparam logic [15:0] BOUND_RST = 16'h0000;
	localparam logic [15:0] BITREV_RST = 16'h0000;
	// Pointer select value that disables a feature
	localparam logic [3:0] SEL_OFF = 4'hF;
	// Working registers with fixed roles in dual-operand reads
	localparam logic [3:0] WREG_8 = 4'h8;
	localparam logic [3:0] WREG_9 = 4'h9;
	localparam logic [3:0] WREG_10 = 4'hA;
	localparam logic [3:0] WREG_11 = 4'hB;
	// Addressing modes
	typedef enum logic [2:0] {
		AGM_DIRECT, AGM_INDIRECT, AGM_POST_MOD, AGM_PRE_MOD,
		AGM_REG_OFFSET, AGM_LIT_OFFSET, AGM_LITERAL
	} agm_mode_t;
	// Literal widths
	typedef enum logic [1:0] {AGM_LIT8, AGM_LIT16, AGM_LIT14U, AGM_LIT16S} agm_lit_t;
endpackage

/* agm_modulo.sv */
// Modulo correction for one address generator.
// Assumes start and end registers describe a valid buffer.
`timescale 1ns/1ps
module agm_modulo (
	// Buffer description
	input wire logic [15:0] buf_start,
	input wire logic [15:0] buf_end,
	input wire logic word_only,
	input wire logic active,
	// Address in and out
	input wire logic [15:0] base,
	input wire logic [15:0] addr_in,
	output logic [15:0] addr_out
);
	logic [16:0] length; // End minus start plus one byte
	logic bidir; // Power-of-two length
	logic up; // Step direction
	logic [15:0] raw;
	always_comb begin
		// Y ends are stored on their odd byte, so this is the byte length in both spaces
		length = {1'b0, buf_end} - {1'b0, buf_start} + 17'h00001;
		bidir = (length & (length - 17'h00001)) == 17'h00000;
		up = addr_in >= base;
		raw = addr_in;
		if (!active) begin
			raw = addr_in;
		end else if ((up || bidir) && addr_in > buf_end) begin
			raw = addr_in - length[15:0];
		end else if ((!up || bidir) && addr_in < buf_start) begin
			raw = addr_in + length[15:0];
		end
		addr_out = word_only ? {raw[15:1], 1'b0} : raw;
	end
endmodule

/* agm_top.sv */
// Effective address generator with modulo and bit-reversed addressing.
// Assumes the decoder gives mode, registers and literals in one cycle.
//
// What this block does
// - Indexed and 8/16-bit literals for moves.
// - One offset field shared by both operands.
// - Registers 8,9 go X; 10,11 go Y.
// - Indexed dual-operand only via registers 9 and 11.
// - Dual-operand: indirect, indexed, post-modify 2/4/6.
// - One buffer in X, one in Y.
// - X modulo on any working register but 15, any space; Y on 10,11.
// - Power-of-two buffers check both bounds.
// - Four 16-bit bound registers give length.
// - Y modulo addresses keep bit zero clear.
// - X modulo needs select not 15, bit 15.
// - Y modulo needs select not 15, bit 14.
// - Bounds compared by greater or less.
// - Write back only in pre/post modify.
// - Bit reverse only on X writes.
// - Pointer and modifier added with reversed carry.
// - Bit reverse needs select, enable, increment mode.
// - Bit reverse beats modulo on X writes.
`timescale 1ns/1ps
module agm_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	// Move/accumulator operand request
	input wire logic op_valid,
	input wire logic op_is_dest,
	input wire agm_pkg::agm_mode_t op_mode,
	input wire logic [3:0] op_ptr_sel,
	input wire logic [15:0] op_ptr_val,
	input wire logic [15:0] op_offset_val,
	input wire logic [3:0] offset_register_field,
	input wire logic [15:0] op_mod_const,
	input wire logic op_word,
	input wire agm_pkg::agm_lit_t op_lit_kind,
	input wire logic [15:0] op_literal,
	// Dual-operand prefetch request
	input wire logic mac_valid,
	input wire logic [3:0] mac_x_sel,
	input wire logic [3:0] mac_y_sel,
	input wire logic [15:0] mac_x_ptr,
	input wire logic [15:0] mac_y_ptr,
	input wire logic [1:0] mac_x_mode,
	input wire logic [1:0] mac_y_mode,
	input wire logic [15:0] mac_x_off,
	input wire logic [15:0] mac_y_off,
	// Move/accumulator results
	output logic op_done,
	output logic [15:0] op_addr,
	output logic [15:0] op_literal_out,
	output logic op_wb_en,
	output logic [3:0] op_wb_sel,
	output logic [15:0] op_wb_val,
	output logic [3:0] op_offset_sel,
	// Dual-operand results
	output logic mac_done,
	output logic mac_error,
	output logic [15:0] x_read_addr,
	output logic [15:0] y_read_addr,
	output logic x_wb_en,
	output logic [15:0] x_wb_val,
	output logic y_wb_en,
	output logic [15:0] y_wb_val
);
	// Registers
	logic [15:0] modulo_bitrev_control_reg;
	logic [15:0] x_buffer_start_reg;
	logic [15:0] x_buffer_end_reg;
	logic [15:0] y_buffer_start_reg;
	logic [15:0] y_buffer_end_reg;
	logic [15:0] bitrev_modifier_register_reg;
	// Decoded fields
	logic [3:0] x_modulo_pointer_select;
	logic [3:0] y_modulo_pointer_select;
	logic [3:0] bitrev_pointer_select;
	logic x_modulo_enable;
	logic y_modulo_enable;
	logic bitrev_enable;

	// Reverse-carry add: pointer and modifier both bit reversed, summed, and the sum reversed back
	function automatic logic [15:0] rev_add(input logic [15:0] a, input logic [15:0] m);
		logic [15:0] ra;
		logic [15:0] rm;
		logic [15:0] s;
		ra = '0;
		rm = '0;
		for (int i = 0; i < 16; i++) begin
			ra[i] = a[15 - i];
			rm[i] = m[15 - i];
		end
		s = ra + rm;
		for (int i = 0; i < 16; i++) begin
			ra[i] = s[15 - i];
		end
		return ra;
	endfunction

	// Mode selects a post-modify step of 2, 4 or 6 for dual-operand pointers
	function automatic logic [15:0] mac_step(input logic [1:0] m);
		case (m)
			2'h1: mac_step = 16'h0002;
			2'h2: mac_step = 16'h0004;
			2'h3: mac_step = 16'h0006;
			default: mac_step = 16'h0000;
		endcase
	endfunction

	assign x_modulo_pointer_select = modulo_bitrev_control_reg[agm_pkg::XSEL_LSB +: 4];
	assign y_modulo_pointer_select = modulo_bitrev_control_reg[agm_pkg::YSEL_LSB +: 4];
	assign bitrev_pointer_select = modulo_bitrev_control_reg[agm_pkg::BRSEL_LSB +: 4];
	assign x_modulo_enable = modulo_bitrev_control_reg[agm_pkg::XEN_BIT];
	assign y_modulo_enable = modulo_bitrev_control_reg[agm_pkg::YEN_BIT];
	assign bitrev_enable = bitrev_modifier_register_reg[agm_pkg::BITREV_ENABLE_BIT];

	// Register writes
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			modulo_bitrev_control_reg <= agm_pkg::CONTROL_RST;
			x_buffer_start_reg <= agm_pkg::BOUND_RST;
			x_buffer_end_reg <= agm_pkg::BOUND_RST;
			y_buffer_start_reg <= agm_pkg::BOUND_RST;
			y_buffer_end_reg <= agm_pkg::BOUND_RST;
			bitrev_modifier_register_reg <= agm_pkg::BITREV_RST;
		end else if (reg_write) begin
			case (reg_addr)
				agm_pkg::OFS_CONTROL: modulo_bitrev_control_reg <= reg_wdata;
				agm_pkg::OFS_X_START: x_buffer_start_reg <= reg_wdata;
				agm_pkg::OFS_X_END: x_buffer_end_reg <= reg_wdata;
				// Y bounds are word aligned
				agm_pkg::OFS_Y_START: y_buffer_start_reg <= {reg_wdata[15:1], 1'b0};
				agm_pkg::OFS_Y_END: y_buffer_end_reg <= {reg_wdata[15:1], 1'b1};
				agm_pkg::OFS_BITREV: bitrev_modifier_register_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_read) begin
			case (reg_addr)
				agm_pkg::OFS_CONTROL: reg_rdata <= modulo_bitrev_control_reg;
				agm_pkg::OFS_X_START: reg_rdata <= x_buffer_start_reg;
				agm_pkg::OFS_X_END: reg_rdata <= x_buffer_end_reg;
				agm_pkg::OFS_Y_START: reg_rdata <= y_buffer_start_reg;
				agm_pkg::OFS_Y_END: reg_rdata <= y_buffer_end_reg;
				agm_pkg::OFS_BITREV: reg_rdata <= bitrev_modifier_register_reg;
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// Move/accumulator address path
	logic x_mod_on; // X modulo gate, shared by read and write generators
	logic y_mod_on;
	logic op_mod_hit;
	logic bitrev_on;
	logic [15:0] op_raw;
	logic [15:0] op_new_ptr;
	logic [15:0] op_corr;
	logic [15:0] lit_val;
	assign x_mod_on = x_modulo_enable && (x_modulo_pointer_select != agm_pkg::SEL_OFF);
	assign y_mod_on = y_modulo_enable && (y_modulo_pointer_select != agm_pkg::SEL_OFF);
	// Bit reverse only on word writes with pre/post increment
	assign bitrev_on = op_is_dest && op_word && bitrev_enable &&
		(bitrev_pointer_select != agm_pkg::SEL_OFF) &&
		(op_ptr_sel == bitrev_pointer_select) &&
		((op_mode == agm_pkg::AGM_POST_MOD) || (op_mode == agm_pkg::AGM_PRE_MOD)) &&
		!op_mod_const[15];
	// Modulo on the chosen register in any space; bit reverse wins on writes
	assign op_mod_hit = x_mod_on && (op_ptr_sel == x_modulo_pointer_select) &&
		!bitrev_on;

	always_comb begin
		op_raw = op_ptr_val;
		op_new_ptr = op_ptr_val + op_mod_const;
		case (op_mode)
			agm_pkg::AGM_POST_MOD: op_raw = op_ptr_val;
			agm_pkg::AGM_PRE_MOD: op_raw = op_new_ptr;
			agm_pkg::AGM_REG_OFFSET: op_raw = op_ptr_val + op_offset_val;
			agm_pkg::AGM_LIT_OFFSET: op_raw = op_ptr_val + op_literal;
			default: op_raw = op_ptr_val;
		endcase
		if (bitrev_on) begin
			// Modifier added in reversed order, offset ignored
			op_new_ptr = rev_add(op_ptr_val, {bitrev_modifier_register_reg[14:0], 1'b0});
			op_new_ptr[0] = 1'b0;
			if (op_mode == agm_pkg::AGM_PRE_MOD) begin
				op_raw = op_new_ptr;
			end
		end
	end

	// Literal formatting by instruction kind
	always_comb begin
		case (op_lit_kind)
			agm_pkg::AGM_LIT8: lit_val = {8'h00, op_literal[7:0]};
			agm_pkg::AGM_LIT14U: lit_val = {2'h0, op_literal[13:0]};
			agm_pkg::AGM_LIT16S: lit_val = op_literal;
			default: lit_val = op_literal;
		endcase
	end

	// Corrected new pointer for write back
	logic [15:0] op_ptr_corr;
	agm_modulo u_op_ea (
		.buf_start(x_buffer_start_reg),
		.buf_end(x_buffer_end_reg),
		.word_only(1'b0),
		.active(op_mod_hit),
		.base(op_ptr_val),
		.addr_in(op_raw),
		.addr_out(op_corr)
	);
	agm_modulo u_op_wb (
		.buf_start(x_buffer_start_reg),
		.buf_end(x_buffer_end_reg),
		.word_only(1'b0),
		.active(op_mod_hit),
		.base(op_ptr_val),
		.addr_in(op_new_ptr),
		.addr_out(op_ptr_corr)
	);

	// Registered move/accumulator outputs
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			op_done <= 1'b0;
			op_addr <= 16'h0000;
			op_literal_out <= 16'h0000;
			op_wb_en <= 1'b0;
			op_wb_sel <= 4'h0;
			op_wb_val <= 16'h0000;
			op_offset_sel <= 4'h0;
		end else begin
			op_done <= op_valid;
			if (op_valid) begin
				op_addr <= op_corr;
				op_literal_out <= lit_val;
				op_offset_sel <= offset_register_field;
				op_wb_sel <= op_ptr_sel;
				op_wb_val <= op_ptr_corr;
				op_wb_en <= (op_mode == agm_pkg::AGM_POST_MOD) ||
					(op_mode == agm_pkg::AGM_PRE_MOD);
			end else begin
				op_wb_en <= 1'b0;
			end
		end
	end

	// Dual-operand prefetch: modes 0 indirect, 1..3 post-modify, indexed by offset flag
	logic mac_bad;
	logic x_idx;
	logic y_idx;
	logic [15:0] x_ea_raw;
	logic [15:0] y_ea_raw;
	logic [15:0] x_ea;
	logic [15:0] y_ea;
	logic [15:0] x_np;
	logic [15:0] y_np;
	logic [15:0] x_np_c;
	logic [15:0] y_np_c;
	logic x_mac_mod;
	logic y_mac_mod;
	// Nonzero offset input marks the indexed form
	assign x_idx = mac_x_off != 16'h0000;
	assign y_idx = mac_y_off != 16'h0000;
	assign mac_bad = !((mac_x_sel == agm_pkg::WREG_8) || (mac_x_sel == agm_pkg::WREG_9)) ||
		!((mac_y_sel == agm_pkg::WREG_10) || (mac_y_sel == agm_pkg::WREG_11)) ||
		(x_idx && (mac_x_sel != agm_pkg::WREG_9)) ||
		(y_idx && (mac_y_sel != agm_pkg::WREG_11)) ||
		(x_idx && mac_x_mode != 2'h0) || (y_idx && mac_y_mode != 2'h0);
	assign x_mac_mod = x_mod_on && (mac_x_sel == x_modulo_pointer_select);
	assign y_mac_mod = y_mod_on && (mac_y_sel == y_modulo_pointer_select);
	assign x_ea_raw = mac_x_ptr + mac_x_off;
	assign y_ea_raw = mac_y_ptr + mac_y_off;
	assign x_np = mac_x_ptr + mac_step(mac_x_mode);
	assign y_np = mac_y_ptr + mac_step(mac_y_mode);

	agm_modulo u_x_ea (.buf_start(x_buffer_start_reg), .buf_end(x_buffer_end_reg),
		.word_only(1'b0), .active(x_mac_mod), .base(mac_x_ptr), .addr_in(x_ea_raw),
		.addr_out(x_ea));
	agm_modulo u_x_np (.buf_start(x_buffer_start_reg), .buf_end(x_buffer_end_reg),
		.word_only(1'b0), .active(x_mac_mod), .base(mac_x_ptr), .addr_in(x_np),
		.addr_out(x_np_c));
	agm_modulo u_y_ea (.buf_start(y_buffer_start_reg), .buf_end(y_buffer_end_reg),
		.word_only(1'b1), .active(y_mac_mod), .base(mac_y_ptr), .addr_in(y_ea_raw),
		.addr_out(y_ea));
	agm_modulo u_y_np (.buf_start(y_buffer_start_reg), .buf_end(y_buffer_end_reg),
		.word_only(1'b1), .active(y_mac_mod), .base(mac_y_ptr), .addr_in(y_np),
		.addr_out(y_np_c));

	// Registered dual-operand outputs; a refused request writes nothing back
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mac_done <= 1'b0;
			mac_error <= 1'b0;
			x_read_addr <= 16'h0000;
			y_read_addr <= 16'h0000;
			x_wb_en <= 1'b0;
			x_wb_val <= 16'h0000;
			y_wb_en <= 1'b0;
			y_wb_val <= 16'h0000;
		end else begin
			mac_done <= mac_valid && !mac_bad;
			mac_error <= mac_valid && mac_bad;
			x_wb_en <= mac_valid && !mac_bad && (mac_x_mode != 2'h0);
			y_wb_en <= mac_valid && !mac_bad && (mac_y_mode != 2'h0);
			if (mac_valid && !mac_bad) begin
				x_read_addr <= x_ea;
				y_read_addr <= y_ea;
				x_wb_val <= x_np_c;
				y_wb_val <= y_np_c;
			end
		end
	end

	// Assertions
	a_wb_only_modify: assert property (@(posedge sys_clk) disable iff (!reset_n)
		op_valid && (op_mode == agm_pkg::AGM_REG_OFFSET) |=> !op_wb_en)
		else $error("offset mode wrote the pointer back");
	a_mac_route_bad: assert property (@(posedge sys_clk) disable iff (!reset_n)
		mac_valid && x_idx && (mac_x_sel == agm_pkg::WREG_8) |=> mac_error && !mac_done)
		else $error("indexed access via register 8 accepted");
	a_y_word_align: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(mac_done) |-> !y_read_addr[0])
		else $error("y address odd");
	a_x_mod_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(x_modulo_pointer_select == agm_pkg::SEL_OFF) |-> !op_mod_hit && !x_mac_mod)
		else $error("x modulo active with select 15");
	a_y_mod_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!y_modulo_enable |-> !y_mac_mod)
		else $error("y modulo active while disabled");
	a_br_priority: assert property (@(posedge sys_clk) disable iff (!reset_n)
		bitrev_on |-> op_ptr_corr == op_new_ptr)
		else $error("modulo active with bit reverse");
	a_br_write_only: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!op_is_dest |-> !bitrev_on)
		else $error("bit reverse on a read");
	a_mac_step_wb: assert property (@(posedge sys_clk) disable iff (!reset_n)
		mac_valid && !mac_bad && (mac_x_mode == 2'h2) && !x_mac_mod
		|=> x_wb_en && (x_wb_val == $past(mac_x_ptr) + 16'h0004))
		else $error("post-modify by 4 wrong");
	a_offset_share: assert property (@(posedge sys_clk) disable iff (!reset_n)
		op_valid |=> op_offset_sel == $past(offset_register_field))
		else $error("offset field not passed");
endmodule

/* agm_regfile_model.sv */
// Working register file model standing where the decoder and register file sit.
// Assumes write-backs arrive one cycle after the request, as the generator answers.
`timescale 1ns/1ps
module agm_regfile_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Preload of one register by the bench
	input wire logic ld_en,
	input wire logic [3:0] ld_sel,
	input wire logic [15:0] ld_val,
	// Pointer selection
	input wire logic [3:0] op_ptr_sel,
	input wire logic mac_valid,
	input wire logic [3:0] mac_x_sel,
	input wire logic [3:0] mac_y_sel,
	output logic [15:0] op_ptr_val,
	output logic [15:0] mac_x_ptr,
	output logic [15:0] mac_y_ptr,
	// Write-backs from the generator
	input wire logic op_wb_en,
	input wire logic [3:0] op_wb_sel,
	input wire logic [15:0] op_wb_val,
	input wire logic x_wb_en,
	input wire logic [15:0] x_wb_val,
	input wire logic y_wb_en,
	input wire logic [15:0] y_wb_val
);
	logic [15:0] wreg [16]; // Sixteen working registers
	logic [3:0] x_sel_reg; // Dual-operand X register, kept until its write-back
	logic [3:0] y_sel_reg; // Dual-operand Y register, kept until its write-back

	// Pointers read straight from the file, as a decoder would present them
	assign op_ptr_val = wreg[op_ptr_sel];
	assign mac_x_ptr = wreg[mac_x_sel];
	assign mac_y_ptr = wreg[mac_y_sel];

	// Latch the prefetch registers: the answer lands after the select has moved on
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			x_sel_reg <= 4'h0;
			y_sel_reg <= 4'h0;
		end else if (mac_valid) begin
			x_sel_reg <= mac_x_sel;
			y_sel_reg <= mac_y_sel;
		end
	end

	// Register updates; a write-back wins over a preload to the same register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 16; i++) begin
				wreg[i] <= 16'h0000;
			end
		end else begin
			if (ld_en) begin
				wreg[ld_sel] <= ld_val;
			end
			if (op_wb_en) begin
				wreg[op_wb_sel] <= op_wb_val;
			end
			if (x_wb_en) begin
				wreg[x_sel_reg] <= x_wb_val;
			end
			if (y_wb_en) begin
				wreg[y_sel_reg] <= y_wb_val;
			end
		end
	end
endmodule

/* address_generator_modulo_tb.sv */
// Testbench for the address generator: operand and prefetch tables, then edge cases.
// Assumes the register file model on the far side and one-cycle answers.
`timescale 1ns/1ps
module address_generator_modulo_tb;
	typedef struct {agm_pkg::agm_mode_t m; logic [3:0] s; logic [15:0] p, mc, ofs, ea;
		logic we; logic [15:0] np;} agm_op_row_t;
	typedef struct {logic [3:0] xs, ys; logic [1:0] xm, ym; logic [15:0] xo, yo, xp, yp;
		logic err; logic [15:0] xa, ya; logic xwe, ywe; logic [15:0] xn, yn;} agm_mac_row_t;
	// Clock, reset and register port
	logic sys_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	// Operand request and far-side preload
	logic op_valid = 1'b0, op_is_dest = 1'b0, op_word = 1'b0, ld_en = 1'b0;
	agm_pkg::agm_mode_t op_mode = agm_pkg::AGM_DIRECT;
	agm_pkg::agm_lit_t op_lit_kind = agm_pkg::AGM_LIT8;
	logic [3:0] op_ptr_sel = 4'h0, offset_register_field = 4'h0, ld_sel = 4'h0;
	logic [15:0] op_ptr_val, op_offset_val = 16'h0000, op_mod_const = 16'h0000;
	logic [15:0] op_literal = 16'h0000, ld_val = 16'h0000;
	// Prefetch request
	logic mac_valid = 1'b0;
	logic [3:0] mac_x_sel = 4'h0, mac_y_sel = 4'h0;
	logic [1:0] mac_x_mode = 2'h0, mac_y_mode = 2'h0;
	logic [15:0] mac_x_ptr, mac_y_ptr, mac_x_off = 16'h0000, mac_y_off = 16'h0000;
	// Results
	logic op_done, op_wb_en, mac_done, mac_error, x_wb_en, y_wb_en;
	logic [3:0] op_wb_sel, op_offset_sel;
	logic [15:0] op_addr, op_literal_out, op_wb_val, x_read_addr, y_read_addr, x_wb_val, y_wb_val;
	int failures = 0, checks_done = 0;
	// X buffer 0x1000..0x100F (power of two), Y buffer 0x2000..0x2007
	agm_op_row_t op_rows [7] = '{
		'{agm_pkg::AGM_POST_MOD, 4'h2, 16'h100E, 16'h0002, 16'h0000, 16'h100E, 1'b1, 16'h1000},
		'{agm_pkg::AGM_PRE_MOD, 4'h2, 16'h1000, 16'hFFFC, 16'h0000, 16'h100C, 1'b1, 16'h100C},
		'{agm_pkg::AGM_PRE_MOD, 4'h2, 16'h100C, 16'h0006, 16'h0000, 16'h1002, 1'b1, 16'h1002},
		'{agm_pkg::AGM_REG_OFFSET, 4'h2, 16'h1008, 16'h0000, 16'h000A, 16'h1002, 1'b0, 16'h1008},
		'{agm_pkg::AGM_LIT_OFFSET, 4'h2, 16'h0C00, 16'h0000, 16'h0404, 16'h1004, 1'b0, 16'h0C00},
		'{agm_pkg::AGM_POST_MOD, 4'h3, 16'h100E, 16'h0002, 16'h0000, 16'h100E, 1'b1, 16'h1010},
		'{agm_pkg::AGM_INDIRECT, 4'h2, 16'h1004, 16'h0000, 16'h0000, 16'h1004, 1'b0, 16'h1004}};
	agm_mac_row_t mac_rows [7] = '{
		'{4'h8, 4'hA, 2'h1, 2'h1, 16'h0000, 16'h0000, 16'h0100, 16'h2006, 1'b0, 16'h0100,
			16'h2006, 1'b1, 1'b1, 16'h0102, 16'h2000},
		'{4'h9, 4'hB, 2'h2, 2'h3, 16'h0000, 16'h0000, 16'h0200, 16'h3000, 1'b0, 16'h0200,
			16'h3000, 1'b1, 1'b1, 16'h0204, 16'h3006},
		'{4'h9, 4'hB, 2'h0, 2'h0, 16'h0004, 16'h0008, 16'h0200, 16'h3000, 1'b0, 16'h0204,
			16'h3008, 1'b0, 1'b0, 16'h0200, 16'h3000},
		'{4'h8, 4'hA, 2'h0, 2'h0, 16'h0004, 16'h0000, 16'h0, 16'h0, 1'b1, 16'h0, 16'h0, 1'b0, 1'b0,
			16'h0, 16'h0},
		'{4'h9, 4'hB, 2'h1, 2'h0, 16'h0004, 16'h0000, 16'h0, 16'h0, 1'b1, 16'h0, 16'h0, 1'b0, 1'b0,
			16'h0, 16'h0},
		'{4'hA, 4'hA, 2'h0, 2'h0, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0,
			16'h0},
		'{4'h8, 4'h8, 2'h0, 2'h0, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0,
			16'h0}};
	// Expected literal per kind: 8-bit, 16-bit, 14-bit unsigned, 16-bit signed
	logic [15:0] lit_exp [4] = '{16'h00AB, 16'hFFAB, 16'h3FAB, 16'hFFAB};

	agm_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.op_valid(op_valid), .op_is_dest(op_is_dest), .op_mode(op_mode), .op_ptr_sel(op_ptr_sel),
		.op_ptr_val(op_ptr_val), .op_offset_val(op_offset_val),
		.offset_register_field(offset_register_field), .op_mod_const(op_mod_const),
		.op_word(op_word), .op_lit_kind(op_lit_kind), .op_literal(op_literal),
		.mac_valid(mac_valid), .mac_x_sel(mac_x_sel), .mac_y_sel(mac_y_sel),
		.mac_x_ptr(mac_x_ptr), .mac_y_ptr(mac_y_ptr), .mac_x_mode(mac_x_mode),
		.mac_y_mode(mac_y_mode), .mac_x_off(mac_x_off), .mac_y_off(mac_y_off),
		.op_done(op_done), .op_addr(op_addr), .op_literal_out(op_literal_out),
		.op_wb_en(op_wb_en), .op_wb_sel(op_wb_sel), .op_wb_val(op_wb_val),
		.op_offset_sel(op_offset_sel), .mac_done(mac_done), .mac_error(mac_error),
		.x_read_addr(x_read_addr), .y_read_addr(y_read_addr), .x_wb_en(x_wb_en),
		.x_wb_val(x_wb_val), .y_wb_en(y_wb_en), .y_wb_val(y_wb_val));
	agm_regfile_model partner_u (.sys_clk(sys_clk), .reset_n(reset_n), .ld_en(ld_en),
		.ld_sel(ld_sel), .ld_val(ld_val), .op_ptr_sel(op_ptr_sel), .mac_valid(mac_valid),
		.mac_x_sel(mac_x_sel), .mac_y_sel(mac_y_sel), .op_ptr_val(op_ptr_val),
		.mac_x_ptr(mac_x_ptr), .mac_y_ptr(mac_y_ptr), .op_wb_en(op_wb_en),
		.op_wb_sel(op_wb_sel), .op_wb_val(op_wb_val), .x_wb_en(x_wb_en), .x_wb_val(x_wb_val),
		.y_wb_en(y_wb_en), .y_wb_val(y_wb_val));

	// 25 MHz clock
	always #20 sys_clk = ~sys_clk;

	// Counts and verdict, the single end of the run
	task automatic give_verdict();
		$display("failures %0d checks_done %0d", failures, checks_done);
		if (failures == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One comparison
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Bounded wait for the answer pulse; the pulse stands one cycle only
	task automatic wait_done(input logic mac);
		int i;
		for (i = 0; i < 4; i++) begin
			if ((mac ? (mac_done | mac_error) : op_done) === 1'b1) break;
			@(posedge sys_clk);
			#1;
		end
		if (i == 4) begin
			failures++;
			$display("unexpected done expected 1 seen 0");
			give_verdict();
		end
	endtask

	// Register port cycles
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1;
		chk("reg_rdata", e, reg_rdata);
	endtask

	// Preload a working register; the caller lowers ld_en
	task automatic ld(input logic [3:0] s, input logic [15:0] v);
		@(posedge sys_clk);
		ld_en <= 1'b1;
		ld_sel <= s;
		ld_val <= v;
	endtask

	// One operand request, checked against its row, then the register file
	task automatic do_op(input agm_op_row_t r, input logic dst, input logic wd);
		logic [3:0] f;
		f = ~r.s;
		ld(r.s, r.p);
		@(posedge sys_clk);
		ld_en <= 1'b0;
		op_valid <= 1'b1;
		op_mode <= r.m;
		op_ptr_sel <= r.s;
		op_mod_const <= r.mc;
		op_offset_val <= r.ofs;
		op_literal <= {r.ofs[7:0], r.ofs[15:8]};
		offset_register_field <= f;
		op_is_dest <= dst;
		op_word <= wd;
		@(posedge sys_clk);
		op_valid <= 1'b0;
		#1;
		wait_done(1'b0);
		if (r.m == agm_pkg::AGM_LITERAL) chk("op_literal_out", r.ea, op_literal_out);
		else chk("op_addr", r.ea, op_addr);
		chk("op_offset_sel", 16'(f), 16'(op_offset_sel));
		chk("op_wb_en", 16'(r.we), 16'(op_wb_en));
		if (r.we) chk("op_wb_val", r.np, op_wb_val);
		if (r.we) chk("op_wb_sel", 16'(r.s), 16'(op_wb_sel));
		@(posedge sys_clk);
		#1;
		chk("pointer", r.np, partner_u.wreg[r.s]);
	endtask

	// One prefetch request, checked against its row
	task automatic do_mac(input agm_mac_row_t r);
		ld(r.xs, r.xp);
		ld(r.ys, r.yp);
		@(posedge sys_clk);
		ld_en <= 1'b0;
		mac_valid <= 1'b1;
		mac_x_sel <= r.xs;
		mac_y_sel <= r.ys;
		mac_x_mode <= r.xm;
		mac_y_mode <= r.ym;
		mac_x_off <= r.xo;
		mac_y_off <= r.yo;
		@(posedge sys_clk);
		mac_valid <= 1'b0;
		#1;
		wait_done(1'b1);
		chk("mac_error", 16'(r.err), 16'(mac_error));
		chk("mac_done", 16'(!r.err), 16'(mac_done));
		chk("x_wb_en", 16'(r.xwe), 16'(x_wb_en));
		chk("y_wb_en", 16'(r.ywe), 16'(y_wb_en));
		if (!r.err) chk("x_read_addr", r.xa, x_read_addr);
		if (!r.err) chk("y_read_addr", r.ya, y_read_addr);
		if (r.xwe) chk("x_wb_val", r.xn, x_wb_val);
		if (r.ywe) chk("y_wb_val", r.yn, y_wb_val);
	endtask

	// Main sequence
	initial begin
		agm_op_row_t r;
		repeat (4) @(posedge sys_clk);
		#1;
		chk("op_done", 16'h0000, 16'(op_done));
		chk("reg_rdata", 16'h0000, reg_rdata);
		@(posedge sys_clk);
		reset_n <= 1'b1;
		rd_chk(agm_pkg::OFS_CONTROL, agm_pkg::CONTROL_RST);
		rd_chk(agm_pkg::OFS_X_START, agm_pkg::BOUND_RST);
		rd_chk(agm_pkg::OFS_Y_START, agm_pkg::BOUND_RST);
		rd_chk(agm_pkg::OFS_BITREV, agm_pkg::BITREV_RST);
		wr(agm_pkg::OFS_X_START, 16'h1000);
		wr(agm_pkg::OFS_X_END, 16'h100F);
		wr(agm_pkg::OFS_Y_START, 16'h2001);
		wr(agm_pkg::OFS_Y_END, 16'h2006);
		wr(3'h6, 16'hFFFF);
		rd_chk(3'h6, 16'h0000);
		rd_chk(agm_pkg::OFS_X_END, 16'h100F);
		rd_chk(agm_pkg::OFS_Y_START, 16'h2000);
		rd_chk(agm_pkg::OFS_Y_END, 16'h2007);
		// Pointers 2 and 10 stay clear of the frame and stack registers
		wr(agm_pkg::OFS_CONTROL, 16'hCFA2);
		rd_chk(agm_pkg::OFS_CONTROL, 16'hCFA2);
		for (int i = 0; i < 7; i++) do_op(op_rows[i], 1'b0, 1'b1);
		for (int i = 0; i < 7; i++) do_mac(mac_rows[i]);
		for (int k = 0; k < 4; k++) begin
			op_lit_kind <= agm_pkg::agm_lit_t'(k);
			r = '{agm_pkg::AGM_LITERAL, 4'h1, 16'h0, 16'h0, 16'hABFF, lit_exp[k], 1'b0, 16'h0};
			do_op(r, k[0], 1'b1);
		end
		// Both enables off: no wrap on either side
		wr(agm_pkg::OFS_CONTROL, 16'h0FA2);
		do_op(op_rows[5], 1'b0, 1'b1);
		r = op_rows[0];
		r.np = 16'h1010;
		do_op(r, 1'b0, 1'b1);
		do_mac('{4'h8, 4'hA, 2'h1, 2'h1, 16'h0, 16'h0, 16'h0100, 16'h2006, 1'b0, 16'h0100,
			16'h2006, 1'b1, 1'b1, 16'h0102, 16'h2008});
		// Bit reverse on pointer 4, X modulo on the same pointer
		wr(agm_pkg::OFS_CONTROL, 16'h84F4);
		wr(agm_pkg::OFS_BITREV, 16'h8008);
		r = '{agm_pkg::AGM_POST_MOD, 4'h4, 16'h100E, 16'h0002, 16'h0, 16'h100E, 1'b1, 16'h101E};
		do_op(r, 1'b1, 1'b1);
		r.np = 16'h1000;
		do_op(r, 1'b0, 1'b1);
		do_op(r, 1'b1, 1'b0);
		wr(agm_pkg::OFS_BITREV, 16'h0008);
		do_op(r, 1'b1, 1'b1);
		// Every select at 15: neither bit reverse nor modulo
		wr(agm_pkg::OFS_CONTROL, 16'h8FFF);
		wr(agm_pkg::OFS_BITREV, 16'h8008);
		r.s = 4'hF;
		r.np = 16'h1010;
		do_op(r, 1'b1, 1'b1);
		// Ten-byte buffer: one direction only
		wr(agm_pkg::OFS_CONTROL, 16'h8FF2);
		wr(agm_pkg::OFS_X_END, 16'h1009);
		r = '{agm_pkg::AGM_PRE_MOD, 4'h2, 16'h0FF0, 16'h0002, 16'h0, 16'h0FF2, 1'b1, 16'h0FF2};
		do_op(r, 1'b0, 1'b1);
		r = '{agm_pkg::AGM_POST_MOD, 4'h2, 16'h1008, 16'h0002, 16'h0, 16'h1008, 1'b1, 16'h1000};
		do_op(r, 1'b0, 1'b1);
		// Reset in mid-run restores the registers
		@(posedge sys_clk);
		reset_n <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("mac_done", 16'h0000, 16'(mac_done));
		@(posedge sys_clk);
		reset_n <= 1'b1;
		rd_chk(agm_pkg::OFS_CONTROL, agm_pkg::CONTROL_RST);
		rd_chk(agm_pkg::OFS_X_END, agm_pkg::BOUND_RST);
		give_verdict();
	end
endmodule
